/* File: core/vlsr_regs.v */
// Output ceiling, slew-rate and feedback-ratio command registers of the converter
`timescale 1ns/1ps
`include "vlsr_defs.vh"

module vlsr_regs #(
	parameter MW = 12
) (
	input  wire                 clk,
	input  wire                 rst_n,
	input  wire                 cmd_valid,
	input  wire                 cmd_write,
	input  wire [7:0]           cmd_code,
	input  wire [15:0]          cmd_wdata,
	input  wire                 loop_slave,
	input  wire                 output_on,
	input  wire                 store_all,
	input  wire [MW-1:0]        setpoint,
	input  wire [MW-1:0]        floor_mant,
	input  wire signed [MW-1:0] ref_trim,
	input  wire signed [MW-1:0] margin_high_step,
	input  wire signed [MW-1:0] margin_low_step,
	input  wire                 margin_high_en,
	input  wire                 margin_low_en,
	output reg                  rsp_valid_q,
	output reg                  rsp_hit_q,
	output reg                  rsp_nack_q,
	output reg  [15:0]          rsp_rdata_q,
	output reg  signed [15:0]   error_amp_reference_q,
	output reg  [2:0]           slew_sel_q,
	output reg                  nvm_scale_we_q,
	output reg  [2:0]           nvm_scale_q,
	output reg                  other_fault_flag_q,
	output reg                  output_voltage_warning_flag_q,
	output reg                  limit_warn_set_q,
	output reg                  cml_fault_set_q,
	output reg                  invalid_data_set_q,
	output reg                  invalid_command_fault_q,
	output reg                  smbalert_set_q
);
	reg  [MW-1:0] ceil_q;
	reg  [MW-1:0] ceil_d;
	reg  [6:0]    slew_q;
	reg  [6:0]    slew_d;
	reg  [2:0]    scale_q;
	reg  [2:0]    scale_d;
	reg  [15:0]   rdata_d;
	reg           hit_d;
	reg           nack_d;
	reg           ivd_d;
	reg           ivc_d;
	reg           loop_slave_q;
	reg  [MW*6+4:0] watch_q;
	reg           watch_ok_q;

	wire [MW*6+4:0] watch_d;
	wire signed [15:0] clamped;
	wire          over;
	wire          under;
	wire [2:0]    rate_sel;
	wire          ceil_case;
	wire          floor_case;
	wire          changed;

	// Valid ceiling span for the present ratio
	function ceil_in_range;
		input [MW-1:0] m;
		input [2:0]    s;
		begin
			case (s)
				`VLSR_SCALE_1:
					ceil_in_range = (m >= `VLSR_CEIL_MIN_1) && (m <= `VLSR_CEIL_MAX_1);
				`VLSR_SCALE_HALF:
					ceil_in_range = (m >= `VLSR_CEIL_MIN_HALF) && (m <= `VLSR_CEIL_MAX_HALF);
				`VLSR_SCALE_QTR:
					ceil_in_range = (m >= `VLSR_CEIL_MIN_QTR) && (m <= `VLSR_CEIL_MAX_QTR);
				default:
					ceil_in_range = 1'b0;
			endcase
		end
	endfunction

	vlsr_ref_clamp #(
		.MW(MW)
	) u_clamp (
		.setpoint  (setpoint),
		.ceil_mant (ceil_q),
		.floor_mant(floor_mant),
		.scale     (scale_q),
		.trim      (ref_trim),
		.step_hi   (margin_high_step),
		.step_lo   (margin_low_step),
		.margin_hi (margin_high_en),
		.margin_lo (margin_low_en),
		.target    (),
		.ceil_ref  (),
		.floor_ref (),
		.clamped   (clamped),
		.over      (over),
		.under     (under)
	);

	vlsr_slew_map u_slew (
		.mant    (slew_q),
		.rate_sel(rate_sel)
	);

	// Every input of the effective target is watched, so any change re-runs the check
	assign watch_d = {setpoint, ceil_q, floor_mant, ref_trim, margin_high_step,
		margin_low_step, margin_high_en, margin_low_en, scale_q};
	assign changed = watch_ok_q && (watch_d != watch_q);
	assign ceil_case  = over || (ceil_q <= floor_mant);
	assign floor_case = under && !ceil_case;

	// Command decode: read data, write acceptance and fault classification
	always @* begin
		ceil_d  = ceil_q;
		slew_d  = slew_q;
		scale_d = scale_q;
		rdata_d = 16'h0000;
		hit_d   = 1'b0;
		nack_d  = 1'b0;
		ivd_d   = 1'b0;
		ivc_d   = 1'b0;
		if (cmd_valid) begin
			case (cmd_code)
				`VLSR_CODE_CEIL, `VLSR_CODE_SLEW, `VLSR_CODE_SCALE: hit_d = 1'b1;
				default: hit_d = 1'b0;
			endcase
		end
		if (hit_d && loop_slave_q) begin
			nack_d = 1'b1;
			ivc_d  = 1'b1;
		end else if (hit_d && !cmd_write) begin
			case (cmd_code)
				`VLSR_CODE_CEIL:
					rdata_d = {{(16-MW){1'b0}}, ceil_q};
				`VLSR_CODE_SLEW:
					rdata_d = {`VLSR_SLEW_EXP, 4'h0, slew_q};
				default:
					rdata_d = {`VLSR_SCALE_EXP, 8'h00, scale_q};
			endcase
		end else if (hit_d) begin
			case (cmd_code)
				`VLSR_CODE_CEIL: begin
					if (ceil_in_range(cmd_wdata[MW-1:0], scale_q))
						ceil_d = cmd_wdata[MW-1:0];
					else begin
						nack_d = 1'b1;
						ivd_d  = 1'b1;
					end
				end
				`VLSR_CODE_SLEW:
					slew_d = cmd_wdata[6:0];
				default: begin
					// Accepted in any operating state other than loop slave, output on or off
					if (cmd_wdata == {`VLSR_SCALE_EXP, 8'h00, `VLSR_SCALE_1} ||
						cmd_wdata == {`VLSR_SCALE_EXP, 8'h00, `VLSR_SCALE_HALF} ||
						cmd_wdata == {`VLSR_SCALE_EXP, 8'h00, `VLSR_SCALE_QTR})
						scale_d = cmd_wdata[2:0];
					else begin
						nack_d = 1'b1;
						ivd_d  = 1'b1;
					end
				end
			endcase
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			ceil_q                        <= `VLSR_CEIL_RST;
			slew_q                        <= `VLSR_SLEW_RST;
			scale_q                       <= `VLSR_SCALE_RST;
			loop_slave_q                  <= 1'b0;
			watch_q                       <= {(MW*6+5){1'b0}};
			watch_ok_q                    <= 1'b0;
			rsp_valid_q                   <= 1'b0;
			rsp_hit_q                     <= 1'b0;
			rsp_nack_q                    <= 1'b0;
			rsp_rdata_q                   <= 16'h0000;
			error_amp_reference_q         <= 16'sh0000;
			slew_sel_q                    <= 3'h0;
			nvm_scale_we_q                <= 1'b0;
			nvm_scale_q                   <= 3'h0;
			other_fault_flag_q            <= 1'b0;
			output_voltage_warning_flag_q <= 1'b0;
			limit_warn_set_q              <= 1'b0;
			cml_fault_set_q               <= 1'b0;
			invalid_data_set_q            <= 1'b0;
			invalid_command_fault_q       <= 1'b0;
			smbalert_set_q                <= 1'b0;
		end else begin
			ceil_q       <= ceil_d;
			slew_q       <= slew_d;
			scale_q      <= scale_d;
			loop_slave_q <= loop_slave;
			watch_q      <= watch_d;
			watch_ok_q   <= 1'b1;
			rsp_valid_q  <= cmd_valid;
			rsp_hit_q    <= hit_d;
			rsp_nack_q   <= nack_d;
			rsp_rdata_q  <= rdata_d;
			// Ramp logic slews toward this value at the selected rate outside soft ramps
			error_amp_reference_q <= clamped;
			slew_sel_q            <= rate_sel;
			nvm_scale_we_q        <= store_all;
			nvm_scale_q           <= scale_q;
			// Limit warnings only while the output is on and an input changed
			other_fault_flag_q            <= changed && output_on && (ceil_case || floor_case);
			output_voltage_warning_flag_q <= changed && output_on && (ceil_case || floor_case);
			limit_warn_set_q              <= changed && output_on && (ceil_case || floor_case);
			cml_fault_set_q               <= ivd_d;
			invalid_data_set_q            <= ivd_d;
			invalid_command_fault_q       <= ivc_d;
			smbalert_set_q <= ivd_d || ivc_d ||
				(changed && output_on && (ceil_case || floor_case));
		end
	end
endmodule // vlsr_regs

/* File: pkg/vlsr_defs.vh */
// Command codes, field layouts, reset values and limits of the output-limit register bank
`ifndef VLSR_DEFS_VH
`define VLSR_DEFS_VH

`define VLSR_CODE_CEIL        8'h24
`define VLSR_CODE_SLEW        8'h27
`define VLSR_CODE_SCALE       8'h29

`define VLSR_CEIL_EXP         5'h17
`define VLSR_SLEW_EXP         5'h1a
`define VLSR_SCALE_EXP        5'h1e

`define VLSR_CEIL_RST         12'h34d
`define VLSR_SLEW_RST         7'h3c
`define VLSR_SCALE_RST        3'h4

`define VLSR_SCALE_1          3'h4
`define VLSR_SCALE_HALF       3'h2
`define VLSR_SCALE_QTR        3'h1

`define VLSR_CEIL_MIN_1       12'h11a
`define VLSR_CEIL_MAX_1       12'h34d
`define VLSR_CEIL_MIN_HALF    12'h234
`define VLSR_CEIL_MAX_HALF    12'h69a
`define VLSR_CEIL_MIN_QTR     12'h468
`define VLSR_CEIL_MAX_QTR     12'hc00

`define VLSR_SLEW_B0          7'h05
`define VLSR_SLEW_B1          7'h07
`define VLSR_SLEW_B2          7'h0c
`define VLSR_SLEW_B3          7'h11
`define VLSR_SLEW_B4          7'h19
`define VLSR_SLEW_B5          7'h2f
`define VLSR_SLEW_B6          7'h4f

`endif

/* File: core/vlsr_slew_map.v */
// Maps a transition-rate mantissa onto one of the eight fixed slew rates
`timescale 1ns/1ps
`include "vlsr_defs.vh"

module vlsr_slew_map (
	input  wire [6:0] mant,
	output reg  [2:0] rate_sel
);
	// Codes 0..7 stand for 0.067, 0.1, 0.143, 0.222, 0.333, 0.5, 1 and 1.5 mV/us
	always @* begin
		if (mant <= `VLSR_SLEW_B0)
			rate_sel = 3'h0;
		else if (mant <= `VLSR_SLEW_B1)
			rate_sel = 3'h1;
		else if (mant <= `VLSR_SLEW_B2)
			rate_sel = 3'h2;
		else if (mant <= `VLSR_SLEW_B3)
			rate_sel = 3'h3;
		else if (mant <= `VLSR_SLEW_B4)
			rate_sel = 3'h4;
		else if (mant <= `VLSR_SLEW_B5)
			rate_sel = 3'h5;
		else if (mant <= `VLSR_SLEW_B6)
			rate_sel = 3'h6;
		else
			rate_sel = 3'h7;
	end
endmodule // vlsr_slew_map

/* File: core/vlsr_ref_clamp.v */
// Effective reference, ceiling and floor arithmetic with the clamp decision
`timescale 1ns/1ps

module vlsr_ref_clamp #(
	parameter MW = 12
) (
	input  wire [MW-1:0]        setpoint,
	input  wire [MW-1:0]        ceil_mant,
	input  wire [MW-1:0]        floor_mant,
	input  wire [2:0]           scale,
	input  wire signed [MW-1:0] trim,
	input  wire signed [MW-1:0] step_hi,
	input  wire signed [MW-1:0] step_lo,
	input  wire                 margin_hi,
	input  wire                 margin_lo,
	output wire signed [15:0]   target,
	output wire signed [15:0]   ceil_ref,
	output wire signed [15:0]   floor_ref,
	output reg  signed [15:0]   clamped,
	output wire                 over,
	output wire                 under
);
	// Ratio mantissa counts quarters, so the product is shifted right by two
	function [15:0] scaled;
		input [MW-1:0] m;
		input [2:0]    s;
		reg   [MW+2:0] p;
		begin
			p = m * s;
			scaled = {{(16-(MW+1)){1'b0}}, p[MW+2:2]};
		end
	endfunction

	assign ceil_ref  = scaled(ceil_mant, scale);
	assign floor_ref = scaled(floor_mant, scale);
	assign target = scaled(setpoint, scale) + {{(16-MW){trim[MW-1]}}, trim}
		+ (margin_hi ? {{(16-MW){step_hi[MW-1]}}, step_hi} : 16'sh0000)
		+ (margin_lo ? {{(16-MW){step_lo[MW-1]}}, step_lo} : 16'sh0000);
	assign over  = target > ceil_ref;
	assign under = target < floor_ref;

	// Ceiling check repeated after the floor so that a ceiling below the floor still wins
	always @* begin
		if (over)
			clamped = ceil_ref;
		else if (under)
			clamped = floor_ref;
		else
			clamped = target;
		if (clamped > ceil_ref)
			clamped = ceil_ref;
	end
endmodule // vlsr_ref_clamp

/* File: dv/vlsr_host.sv */
// Host-side command driver standing in for the bus controller
`timescale 1ns/1ps
module vlsr_host (
	input  logic        clk,
	input  logic        rsp_valid_q,
	input  logic        rsp_hit_q,
	input  logic        rsp_nack_q,
	input  logic [15:0] rsp_rdata_q,
	output logic        cmd_valid,
	output logic        cmd_write,
	output logic [7:0]  cmd_code,
	output logic [15:0] cmd_wdata,
	output logic        ok,
	output logic [17:0] got
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// One command at a time; the bench writes the ceiling under the reset ratio before it sends any ratio
	task xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
		int i;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code  = c;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		// Stale data is scrambled so nothing can lean on a held bus
		cmd_wdata = ~d;
		ok = 1'b0;
		for (i = 0; i < 4 && !ok; i++) begin
			if (rsp_valid_q === 1'b1)
				ok = 1'b1;
			else
				@(negedge clk);
		end
		got = {rsp_hit_q, rsp_nack_q, rsp_rdata_q};
	endtask
endmodule // vlsr_host

/* File: dv/vlsr_regs_chk.sv */
// Port-level assertions for the output-limit register bank
`timescale 1ns/1ps
module vlsr_regs_chk (
	input logic        clk,
	input logic        rst_n,
	input logic        cmd_valid,
	input logic        cmd_write,
	input logic [7:0]  cmd_code,
	input logic [15:0] cmd_wdata,
	input logic        loop_slave,
	input logic        output_on,
	input logic        store_all,
	input logic        rsp_valid_q,
	input logic        rsp_hit_q,
	input logic        rsp_nack_q,
	input logic [15:0] rsp_rdata_q,
	input logic        nvm_scale_we_q,
	input logic        other_fault_flag_q,
	input logic        output_voltage_warning_flag_q,
	input logic        limit_warn_set_q,
	input logic        cml_fault_set_q,
	input logic        invalid_data_set_q,
	input logic        invalid_command_fault_q,
	input logic        smbalert_set_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire hit = cmd_code == 8'h24 || cmd_code == 8'h27 || cmd_code == 8'h29;
	sequence s_take; cmd_valid && hit && !loop_slave; endsequence
	sequence s_slave; cmd_valid && hit && loop_slave; endsequence
	sequence s_read(c); s_take ##0 !cmd_write && cmd_code == c; endsequence
	property p_answer; cmd_valid |=> rsp_valid_q && rsp_hit_q == $past(hit); endproperty
	a_answer: assert property (p_answer) else $error("answer missing or wrong hit");
	property p_slave; s_slave |=> rsp_nack_q && invalid_command_fault_q && smbalert_set_q; endproperty
	a_slave: assert property (p_slave) else $error("slave access not refused");
	property p_ceil_rd; s_read(8'h24) |=> rsp_rdata_q[15:12] == 4'h0; endproperty
	a_ceil_rd: assert property (p_ceil_rd) else $error("ceiling top bits not zero");
	property p_slew_rd; s_read(8'h27) |=> rsp_rdata_q[15:7] == 9'h1a0; endproperty
	a_slew_rd: assert property (p_slew_rd) else $error("slew exponent wrong");
	property p_scale_rd; s_read(8'h29) |=> rsp_rdata_q[15:3] == 13'h1e00; endproperty
	a_scale_rd: assert property (p_scale_rd) else $error("ratio exponent wrong");
	property p_scale_bad;
		s_take ##0 cmd_write && cmd_code == 8'h29 && !(cmd_wdata inside {16'hf004, 16'hf002, 16'hf001})
		|=> rsp_nack_q && cml_fault_set_q && invalid_data_set_q && smbalert_set_q;
	endproperty
	a_scale_bad: assert property (p_scale_bad) else $error("bad ratio not flagged");
	property p_flags;
		other_fault_flag_q |-> output_voltage_warning_flag_q && limit_warn_set_q && smbalert_set_q;
	endproperty
	a_flags: assert property (p_flags) else $error("clamp flags incomplete");
	property p_quiet; !output_on |=> !other_fault_flag_q; endproperty
	a_quiet: assert property (p_quiet) else $error("clamp flagged with output off");
	property p_store; store_all |=> nvm_scale_we_q; endproperty
	a_store: assert property (p_store) else $error("store not issued");
	property p_nack;
		rsp_nack_q |-> invalid_command_fault_q
			|| (cml_fault_set_q && invalid_data_set_q && smbalert_set_q);
	endproperty
	a_nack: assert property (p_nack) else $error("refusal without fault flags");
endmodule // vlsr_regs_chk
bind vlsr_regs vlsr_regs_chk chk (.*);

/* File: dv/vlsr_regs_tb.sv */
// Self-checking bench for the output-limit register bank
`timescale 1ns/1ps
module vlsr_regs_tb;
	typedef struct packed {logic w; logic [7:0] c; logic [15:0] d; logic [17:0] e;} vlsr_row_t;
	logic clk = 1'b0, rst_n = 1'b0, loop_slave = 1'b0, output_on = 1'b0, store_all = 1'b0;
	logic margin_high_en = 1'b0, margin_low_en = 1'b0;
	logic [11:0] setpoint = 12'h1e6, floor_mant = 12'h0b3;
	logic signed [11:0] ref_trim = -12'sd6, margin_high_step = 12'sd500, margin_low_step = -12'sd10;
	logic cmd_valid, cmd_write, ok, rsp_valid_q, rsp_hit_q, rsp_nack_q, nvm_scale_we_q;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_rdata_q;
	logic [17:0] got;
	logic signed [15:0] error_amp_reference_q;
	logic [2:0] slew_sel_q, nvm_scale_q;
	logic other_fault_flag_q, output_voltage_warning_flag_q, limit_warn_set_q, cml_fault_set_q;
	logic invalid_data_set_q, invalid_command_fault_q, smbalert_set_q;
	int failures = 0, n_compared = 0, n_oth = 0, i, j, k;
	int bnd [7] = '{5, 7, 12, 17, 25, 47, 79};
	logic [6:0] sm [15] = '{5, 6, 7, 8, 12, 13, 17, 18, 25, 26, 47, 48, 79, 80, 127};
	vlsr_row_t rows [20] = '{
		'{0, 8'h24, 16'h0000, 18'h2034d}, '{0, 8'h27, 16'h0000, 18'h2d03c},
		'{0, 8'h29, 16'h0000, 18'h2f004}, '{1, 8'h24, 16'h011a, 18'h20000},
		'{0, 8'h24, 16'h0000, 18'h2011a}, '{1, 8'h24, 16'h0119, 18'h30000},
		'{0, 8'h24, 16'h0000, 18'h2011a}, '{1, 8'h24, 16'hf34d, 18'h20000},
		'{0, 8'h24, 16'h0000, 18'h2034d}, '{1, 8'h24, 16'h034e, 18'h30000},
		'{1, 8'h27, 16'hffff, 18'h20000}, '{0, 8'h27, 16'h0000, 18'h2d07f},
		'{1, 8'h29, 16'hf003, 18'h30000}, '{1, 8'h29, 16'hf002, 18'h20000},
		'{1, 8'h24, 16'h0233, 18'h30000}, '{1, 8'h24, 16'h069a, 18'h20000},
		'{1, 8'h29, 16'hf001, 18'h20000}, '{1, 8'h24, 16'h0c01, 18'h30000},
		'{0, 8'h26, 16'h0000, 18'h00000}, '{1, 8'h29, 16'hf004, 18'h20000}};
	vlsr_regs uut (.*);
	vlsr_host host (.*);
	always #2 clk = ~clk;
	always @(negedge clk) if (other_fault_flag_q === 1'b1) n_oth++;
	task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [17:0] e);
		host.xfer(w, c, d);
		chk("ready", 18'h1, {17'h0, ok});
		chk("resp", e, got);
	endtask
	task settle(input string nm, input int e, input int f);
		repeat (3) @(negedge clk);
		chk(nm, e[17:0], {2'b00, error_amp_reference_q});
		chk("flags", f[17:0], n_oth[17:0]);
	endtask
	task wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		// Rows cover defaults, access kinds and range limits per ratio
		for (i = 0; i < 20; i++) cmd(rows[i].w, rows[i].c, rows[i].d, rows[i].e);
		cmd(1, 8'h24, 16'h034d, 18'h20000);
		for (i = 0; i < 15; i++) begin
			cmd(1, 8'h27, {9'h1a0, sm[i]}, 18'h20000);
			@(negedge clk);
			k = 0;
			for (j = 0; j < 7; j++) if (sm[i] > bnd[j]) k++;
			chk("slew_sel", k[17:0], {15'h0, slew_sel_q});
		end
		output_on = 1'b1;
		margin_low_en = 1'b1;
		settle("ref", 470, 0);
		margin_high_en = 1'b1;
		settle("ceil", 845, 1);
		margin_high_en = 1'b0;
		settle("ref", 470, 1);
		setpoint = 12'h384;
		settle("setpt", 845, 2);
		setpoint = 12'h1e6;
		settle("ref", 470, 2);
		floor_mant = 12'h384;
		settle("floor", 845, 3);
		floor_mant = 12'h0b3;
		output_on = 1'b0;
		margin_high_en = 1'b1;
		settle("off", 845, 3);
		margin_high_en = 1'b0;
		output_on = 1'b1;
		cmd(1, 8'h29, 16'hf002, 18'h20000);
		settle("half", 227, 3);
		store_all = 1'b1;
		@(negedge clk);
		store_all = 1'b0;
		chk("store", 18'ha, {14'h0, nvm_scale_we_q, nvm_scale_q});
		loop_slave = 1'b1;
		repeat (2) @(negedge clk);
		foreach (bnd[j]) if (j < 3) begin
			cmd(1, j == 0 ? 8'h24 : j == 1 ? 8'h27 : 8'h29, 16'hf004, 18'h30000);
			cmd(0, j == 0 ? 8'h24 : j == 1 ? 8'h27 : 8'h29, 16'h0000, 18'h30000);
		end
		loop_slave = 1'b0;
		repeat (2) @(negedge clk);
		cmd(0, 8'h29, 16'h0000, 18'h2f002);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		cmd(0, 8'h29, 16'h0000, 18'h2f004);
		chk("slew_rst", 18'h6, {15'h0, slew_sel_q});
		wrap_up();
	end
endmodule // vlsr_regs_tb
